/* File: hw/txsc_irq_gate.sv */
// one interrupt source gate: local and global enable qualify an event
// assumes event is a one-cycle pulse in the sys_clk domain
`timescale 1ns/10ps
module txsc_irq_gate
  import txsc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic event_in,
  input  wire logic local_en,
  input  wire logic global_en,
  output logic      irq_pulse
);

  typedef struct packed {
    logic pulse;
  } txsc_gate_s;

  txsc_gate_s st;
  txsc_gate_s next_st;

  // pulse when both enables are high at the event
  always_comb begin
    next_st       = st;
    next_st.pulse = event_in & local_en & global_en;
  end

  // state register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign irq_pulse = st.pulse;

endmodule : txsc_irq_gate

/* File: hw/txsc_pkg.sv */
// package for the transmit subaddress control word block
// assumes one subaddress word per instance, host access by plain strobes
package txsc_pkg;

  // ************************************************************
  // word layout
  // ************************************************************
  localparam int          TXSC_W          = 16;
  localparam int          B_PP_EN         = 2;
  localparam int          B_STOP_PP       = 3;
  localparam int          B_PP_ACK        = 8;
  localparam int          B_BROADCAST_FLAG         = 9;
  localparam int          B_BUF_B         = 10;
  localparam int          B_ACCESSED      = 11;
  localparam int          B_FORCE_BUSY    = 12;
  localparam int          B_ACC_IRQ       = 14;
  localparam int          B_IDX_IRQ       = 15;
  localparam logic [15:0] TXSC_RESET      = 16'h0000;
  // host may write these at any time (3, 12, 14, 15)
  localparam logic [15:0] MASK_ANYTIME    = 16'hD008;
  // host may write these only while halted (0-2, 4-7)
  localparam logic [15:0] MASK_HALTED     = 16'h00F7;
  // device status bits (8-11)
  localparam logic [15:0] MASK_DEVICE     = 16'h0F00;
  // bits cleared by soft reset (9, 10, 11)
  localparam logic [15:0] MASK_SOFT_CLR   = 16'h0E00;

  // ************************************************************
  // command limits
  // ************************************************************
  localparam logic [4:0]  SA_MIN          = 5'h01;
  localparam logic [4:0]  SA_MAX          = 5'h1E;

  // completed command as seen by this word
  typedef struct packed {
    logic       done;        // one-cycle pulse at end of processing
    logic       valid;       // command word was valid
    logic       tx;          // transmit/receive bit
    logic [4:0] subaddr;
    logic       broadcast;
    logic       error_free;
    logic       index_zero;  // message_index reached zero / count reached
  } txsc_cmd_s;

  // interrupt events towards pending register and log
  typedef struct packed {
    logic index_zero;
    logic access;
  } txsc_irq_s;

endpackage : txsc_pkg

/* File: hw/txsc_word.sv */
// transmit subaddress control word with host write permissions and status
// assumes strobes and command report are synchronous to sys_clk
//
// Behaviour
// - word applies only to valid transmit commands with subaddress 1 to 30
// - ping-pong written while terminal disabled never acknowledges; one buffer reused
// - bits 8-11 ignore host writes; device updates them while executing
// - host writes to bits 0-2 and 4-7 apply only while not executing
// - host writes to bits 3, 12, 14, 15 apply at any time
// - master reset clears the whole word to zero
// - soft reset clears only accessed, buffer select and broadcast bits
// - a host read of the word clears the accessed bit afterwards, unless a completed command sets it in the same cycle
// - index-zero interrupt needs local and global enable, on index reaching zero
// - index-zero event sets pending bit, asserts interrupt and logs it
// - access interrupt needs local and global enable, on any valid transmit command to subaddress 1 to 30 while executing
// - access event sets pending bit, asserts interrupt and logs it at completion
// - accessed bit sets when message processing completes
// - in ping-pong, buffer select inverts after each error-free completion
// - force_busy answers Busy, sends no data, leaves buffer select alone
`timescale 1ns/10ps
module txsc_word
  import txsc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,            // master reset, active low
  input  wire logic        soft_reset,
  input  wire logic        terminal_enable,
  input  wire logic        terminal_execute,
  input  wire logic        glb_idx_irq_en,
  input  wire logic        glb_acc_irq_en,
  input  wire logic        host_wr,
  input  wire logic [15:0] host_wdata,
  input  wire logic        host_rd,
  input  wire txsc_cmd_s   cmd,
  output logic [15:0]      host_rdata,
  output logic [15:0]      ctrl_word,
  output logic             busy_reply,
  output logic             pp_active,
  output txsc_irq_s        irq_event
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [15:0] word;
    logic [15:0] rdata;
    logic        pp_armed;   // ping-pong enabled while terminal was enabled
  } txsc_state_s;

  txsc_state_s st;
  txsc_state_s next_st;
  logic        hit;          // completed command uses this word
  logic        ack_now;
  logic [15:0] wmask;
  logic        idx_pulse;    // registered index-zero interrupt request
  logic        acc_pulse;    // registered access interrupt request

  // command qualification
  assign hit = cmd.done & cmd.valid & cmd.tx
             & (cmd.subaddr >= SA_MIN) & (cmd.subaddr <= SA_MAX);

  // ping-pong acknowledge follows enable, arm state and stop request
  assign ack_now = st.pp_armed & st.word[B_PP_EN] & ~st.word[B_STOP_PP];

  // host write mask depends on execution state
  assign wmask = terminal_execute ? MASK_ANYTIME
                                  : (MASK_ANYTIME | MASK_HALTED);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st = st;
    // host write, masked bits only
    if (host_wr) begin
      next_st.word = (st.word & ~wmask) | (host_wdata & wmask);
      if (!terminal_execute) begin
        next_st.pp_armed = host_wdata[B_PP_EN] & terminal_enable;
      end
    end
    // read returns the word before the clear
    if (host_rd) begin
      next_st.rdata                = st.word;
      next_st.word[B_ACCESSED]     = 1'b0;
    end
    // device-maintained bits while executing
    if (terminal_execute) begin
      next_st.word[B_PP_ACK] = ack_now;
      if (hit) begin
        next_st.word[B_ACCESSED] = 1'b1;
        if (cmd.broadcast) begin
          next_st.word[B_BROADCAST_FLAG] = 1'b1;
        end
        if (cmd.error_free && st.word[B_PP_ACK] && !st.word[B_FORCE_BUSY]) begin
          next_st.word[B_BUF_B] = ~st.word[B_BUF_B];
        end
      end
    end
    // soft reset clears status only
    if (soft_reset) begin
      next_st.word = next_st.word & ~MASK_SOFT_CLR;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{word: TXSC_RESET, rdata: TXSC_RESET, pp_armed: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // interrupt sources
  // ************************************************************
  txsc_irq_gate u_idx_gate (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .event_in  (hit & terminal_execute & cmd.index_zero),
    .local_en  (st.word[B_IDX_IRQ]),
    .global_en (glb_idx_irq_en),
    .irq_pulse (idx_pulse)
  );

  txsc_irq_gate u_acc_gate (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .event_in  (hit & terminal_execute),
    .local_en  (st.word[B_ACC_IRQ]),
    .global_en (glb_acc_irq_en),
    .irq_pulse (acc_pulse)
  );

  // outputs straight from state
  assign host_rdata = st.rdata;
  assign ctrl_word  = st.word;
  assign busy_reply = st.word[B_FORCE_BUSY];
  assign pp_active  = st.word[B_PP_ACK];
  // both gate flops feed the event struct through one driver
  assign irq_event  = '{index_zero: idx_pulse, access: acc_pulse};

  // ************************************************************
  // checks
  // ************************************************************
  a_unused_bit_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st.word[13] == 1'b0)
    else $error("unused bit 13 is set");

  a_device_bits_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!terminal_execute && !soft_reset) |=> (st.word[11:8] & 4'hD) ==
      ($past(st.word[11:8]) & 4'hD) || $past(host_rd))
    else $error("device bits changed while halted");

  a_halted_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (host_wr && !terminal_execute) |=> st.word[7:0] == $past(host_wdata[7:0]))
    else $error("halted write to low bits lost");

  a_exec_write_block: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (host_wr && terminal_execute) |=> (st.word[7:4] == $past(st.word[7:4]))
      && (st.word[2:0] == $past(st.word[2:0])))
    else $error("low bits written during execution");

  a_anytime_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
    host_wr |=> (st.word & MASK_ANYTIME) == ($past(host_wdata) & MASK_ANYTIME))
    else $error("anytime bits not written");

  a_soft_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (soft_reset && !host_wr && !terminal_execute) |=>
      (st.word[11:9] == 3'h0) && (st.word[7:0] == $past(st.word[7:0])))
    else $error("soft reset clear wrong");

  a_read_clears: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (host_rd && !hit) |=> !st.word[B_ACCESSED] && host_rdata == $past(st.word))
    else $error("read did not clear accessed");

  a_access_sets: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (hit && terminal_execute && !soft_reset) |=> st.word[B_ACCESSED])
    else $error("accessed bit not set");

  a_busy_keeps_buf: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (hit && st.word[B_FORCE_BUSY] && !soft_reset) |=> $stable(st.word[B_BUF_B]))
    else $error("buffer select toggled under busy");

  a_unarmed_no_ack: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!st.pp_armed && terminal_execute) |=> !st.word[B_PP_ACK])  // bit 8 holds while halted
    else $error("ping-pong ack without arming");

  a_acc_irq_once: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (hit && terminal_execute && st.word[B_ACC_IRQ] && glb_acc_irq_en)
      |=> irq_event.access ##1 !irq_event.access || $past(hit, 1))
    else $error("access interrupt missing");

  a_idx_irq_cause: assert property (@(posedge sys_clk) disable iff (!arst_n)
    irq_event.index_zero |-> $past(hit && terminal_execute && cmd.index_zero
      && st.word[B_IDX_IRQ] && glb_idx_irq_en))
    else $error("index-zero interrupt without cause");

  a_idx_irq_fires: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (hit && terminal_execute && cmd.index_zero && st.word[B_IDX_IRQ] && glb_idx_irq_en)
      |=> irq_event.index_zero)
    else $error("index-zero interrupt missing");

  a_acc_irq_cause: assert property (@(posedge sys_clk) disable iff (!arst_n)
    irq_event.access |-> $past(hit && terminal_execute && st.word[B_ACC_IRQ]
      && glb_acc_irq_en))
    else $error("access interrupt without cause");

  a_buf_toggles: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (hit && terminal_execute && cmd.error_free && st.word[B_PP_ACK]
      && !st.word[B_FORCE_BUSY] && !soft_reset)
      |=> st.word[B_BUF_B] != $past(st.word[B_BUF_B]))
    else $error("buffer select did not invert");

  a_ack_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
    terminal_execute |=> st.word[B_PP_ACK] == $past(ack_now))
    else $error("ping-pong ack not updated while executing");

  a_miss_ignored: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cmd.done && !hit && !host_rd && !soft_reset)
      |=> st.word[B_ACCESSED] == $past(st.word[B_ACCESSED]))
    else $error("command outside range touched the word");

endmodule : txsc_word

/* File: tb/testbench.sv */
// testbench: random host, soft reset and command traffic against a reference word
// assumes the word is reached by strobes and commands come from the bus model
`timescale 1ns/10ps
module testbench
  import txsc_pkg::*;
;
  logic        sys_clk, arst_n, soft_reset, term_en, term_exec, glb_idx, glb_acc;
  logic        host_wr, host_rd, send, armed, busy_reply, pp_active;
  logic [15:0] wdata, host_rdata, ctrl_word, m, d;
  logic [1:0]  eirq;
  txsc_cmd_s   req, cmd;
  txsc_irq_s   irq_event;
  int          err_total, n_tests;

  // ************************************************************
  // clock, design and bus model
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  txsc_word txsc_word_inst (.sys_clk(sys_clk), .arst_n(arst_n), .soft_reset(soft_reset),
    .terminal_enable(term_en), .terminal_execute(term_exec), .glb_idx_irq_en(glb_idx),
    .glb_acc_irq_en(glb_acc), .host_wr(host_wr), .host_wdata(wdata), .host_rd(host_rd),
    .cmd(cmd), .host_rdata(host_rdata), .ctrl_word(ctrl_word), .busy_reply(busy_reply),
    .pp_active(pp_active), .irq_event(irq_event));

  txsc_bc_model txsc_bc_model_inst (.sys_clk(sys_clk), .arst_n(arst_n), .send(send),
    .req(req), .cmd(cmd));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic conclude();
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  // one operation, reference update, then compare after the ack lag settles
  task automatic op(input int k);
    logic [15:0] msk;
    eirq = 2'b00;
    msk = MASK_ANYTIME | (term_exec ? 16'h0000 : MASK_HALTED);
    case (k)
      0: begin host_wr = 1'b1; wdata = d; end
      1: host_rd = 1'b1;
      2: begin send = 1'b1; req = txsc_cmd_s'(d[10:0]); end
      3: soft_reset = 1'b1;
      4: term_exec = ~term_exec;
      default: {term_en, glb_idx, glb_acc} = d[2:0];
    endcase
    tick();
    {host_wr, host_rd, send, soft_reset} = 4'h0;
    case (k)
      0: begin
        if (!term_exec) armed = d[B_PP_EN] & term_en;
        m = (m & ~msk) | (d & msk);
      end
      1: begin
        chk("host_rdata", host_rdata, m);
        m[B_ACCESSED] = 1'b0;
      end
      2: begin
        tick();
        if (req.valid && req.tx && req.subaddr >= SA_MIN && req.subaddr <= SA_MAX
            && term_exec) begin
          eirq = {m[B_IDX_IRQ] & glb_idx & req.index_zero, m[B_ACC_IRQ] & glb_acc};
          m[B_ACCESSED] = 1'b1;
          if (req.broadcast) m[B_BROADCAST_FLAG] = 1'b1;
          if (req.error_free && m[B_PP_ACK] && !m[B_FORCE_BUSY]) m[B_BUF_B] = ~m[B_BUF_B];
        end
      end
      3: m = m & ~MASK_SOFT_CLR;
      default: ;
    endcase
    chk("irq_event", {14'h0, irq_event}, {14'h0, eirq});
    tick();
    if (term_exec) m[B_PP_ACK] = armed & m[B_PP_EN] & ~m[B_STOP_PP];
    tick();
    chk("ctrl_word", ctrl_word, m);
    chk("flags", {14'h0, busy_reply, pp_active}, {14'h0, m[B_FORCE_BUSY], m[B_PP_ACK]});
  endtask : op

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    {arst_n, soft_reset, host_wr, host_rd, send} = 5'h00;
    {term_en, term_exec, glb_idx, glb_acc} = 4'h8;
    {wdata, m, d} = 48'h0;
    req = '0;
    armed = 1'b0;
    err_total = 0;
    n_tests = 0;
    void'($urandom(32'h3C67BA83));
    repeat (4) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    chk("reset word", ctrl_word, 16'h0000);
    for (int i = 0; i < 400; i++) begin
      d = 16'($urandom);
      if (i == 200) begin
        arst_n = 1'b0;
        m = 16'h0000;
        armed = 1'b0;
        tick();
        chk("reset word", ctrl_word, 16'h0000);
        arst_n = 1'b1;
      end
      op((i < 2) ? 0 : int'($urandom_range(5)));
    end
    conclude();
  end

  // cut a hang short
  initial begin
    #(100 * 8000);
    err_total++;
    conclude();
  end
endmodule : testbench

/* File: tb/txsc_bc_model.sv */
// bus controller model: reports completed commands to the control word
// assumes send is raised for one cycle, shortly after a rising edge
`timescale 1ns/10ps
module txsc_bc_model
  import txsc_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      arst_n,
  input  wire logic      send,
  input  wire txsc_cmd_s req,
  output txsc_cmd_s      cmd
);
  // done pulses one cycle; idle fields churn so stale values never match
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd <= '0;
    end else if (send) begin
      cmd      <= req;
      cmd.done <= 1'b1;
    end else begin
      cmd <= {1'b0, ~cmd[9:0]};
    end
  end
endmodule : txsc_bc_model
